// *** logic/timer3_control.v ***
// Overview of operation
// - The timer holds its count while the run bit is 0 and counts while it is 1.
// - The 3-bit prescale field divides the timer clock by 1, 2, 4 up to 128.
// - The overflow flag is set whenever the timer count overflows.
// - The overflow flag clears itself when the processor enters this timer's interrupt routine.
// - Software writes may set or clear the overflow flag directly.
// - The baud source bit picks the first timer (0) or this timer (1) overflow for serial port 0.
// - The baud double bit doubles serial port 1's baud rate in its mode 2.
// - The error access bit routes control bit 7 of serial port 1 to the mode bit (0) or framing error (1).
// - Two 8-bit reload registers form the 16-bit reload value, low byte and high byte.
`timescale 1ns/100ps
`include "timer3_defs.vh"

module timer3_control #(
	parameter TIMER_WIDTH = `TIMER_WIDTH
) (
	// Clock and reset.
	input  wire       CLOCK,
	input  wire       RST,
	// Special function register port.
	input  wire [7:0] SFR_ADDR,
	input  wire [7:0] SFR_WDATA,
	input  wire       SFR_WE,
	output reg  [7:0] SFR_RDATA,
	// Interrupt entry acknowledge.
	input  wire       INT_ACK,
	// Baud clock sources and interrupt request.
	input  wire       FIRST_TIMER_OVERFLOW,
	output wire       PORT0_BAUD_TICK,
	output wire       THIRD_TIMER_OVERFLOW,
	output wire       THIRD_TIMER_IRQ,
	// Serial port 1 control.
	input  wire       PORT1_MODE2,
	output wire       PORT1_BAUD_DOUBLE,
	input  wire       PORT1_CTL7_WRITE,
	input  wire       PORT1_CTL7_WDATA,
	output wire       PORT1_MODE_BIT0_WE,
	output wire       PORT1_FRAMING_ERROR_WE,
	output wire       PORT1_CTL7_WDATA_OUT,
	input  wire       PORT1_MODE_BIT0,
	input  wire       PORT1_FRAMING_ERROR,
	output wire       PORT1_CTL7_READ
);

	reg  [7:0]             control_reg;
	reg  [7:0]             reload_low_reg;
	reg  [7:0]             reload_high_reg;
	reg  [TIMER_WIDTH-1:0] count_reg;
	reg  [7:0]             control_next;
	reg                    flag_next;
	wire                   run;
	wire                   tick;
	wire                   overflow;
	wire                   wr_control;
	wire                   wr_reload_low;
	wire                   wr_reload_high;
	wire                   sel_control;
	wire                   sel_reload_low;
	wire                   sel_reload_high;
	wire [`PS_WIDTH-1:0]   third_timer_prescale;
	wire                   third_timer_overflow_flag;
	wire                   port0_baud_source_select;
	wire                   port1_error_access_select;
	wire                   port1_baud_double;
	wire [TIMER_WIDTH-1:0] reload_value;

	// Control fields by name.
	assign run                       = control_reg[`CTL_RUN];
	assign third_timer_prescale      = control_reg[`CTL_PS_HI:`CTL_PS_LO];
	assign third_timer_overflow_flag = control_reg[`CTL_OVF_FLAG];
	assign port0_baud_source_select  = control_reg[`CTL_BAUD_SOURCE];
	assign port1_error_access_select = control_reg[`CTL_ERR_SELECT];
	assign port1_baud_double         = control_reg[`CTL_BAUD_DOUBLE];

	// One decode serves both the write strobes and the read mux, so they cannot disagree.
	assign sel_control     = (SFR_ADDR == `ADDR_CONTROL);
	assign sel_reload_low  = (SFR_ADDR == `ADDR_RELOAD_LOW);
	assign sel_reload_high = (SFR_ADDR == `ADDR_RELOAD_HIGH);
	assign wr_control      = SFR_WE && sel_control;
	assign wr_reload_low   = SFR_WE && sel_reload_low;
	assign wr_reload_high  = SFR_WE && sel_reload_high;

	assign reload_value = {reload_high_reg, reload_low_reg};

	prescale_divider #(
		.SEL_WIDTH (`PS_WIDTH),
		.CNT_WIDTH (`PS_COUNT_WIDTH)
	) u_prescale (
		.clk    (CLOCK),
		.rst    (RST),
		.enable (run),
		.select (third_timer_prescale),
		.tick   (tick)
	);

	assign overflow = tick && (count_reg == {TIMER_WIDTH{1'b1}});

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			count_reg <= {TIMER_WIDTH{1'b0}};
		end else if (overflow) begin
			count_reg <= reload_value;
		end else if (tick) begin
			count_reg <= count_reg + {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Flag next value; a hardware set wins so that no overflow is ever lost to a clear.
	always @* begin
		flag_next = third_timer_overflow_flag;
		if (wr_control) begin
			flag_next = SFR_WDATA[`CTL_OVF_FLAG];
		end
		if (INT_ACK) begin
			flag_next = 1'b0;
		end
		if (overflow) begin
			flag_next = 1'b1;
		end
	end

	// Software owns every other control bit.
	always @* begin
		control_next = control_reg;
		if (wr_control) begin
			control_next = SFR_WDATA;
		end
		control_next[`CTL_OVF_FLAG] = flag_next;
	end

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			control_reg <= `RESET_CONTROL;
		end else begin
			control_reg <= control_next;
		end
	end

	// Reload writes are not blocked while running; the timer picks up the latest bytes at its next overflow.
	// Writes expected while halted.
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			reload_low_reg <= `RESET_RELOAD;
		end else if (wr_reload_low) begin
			reload_low_reg <= SFR_WDATA;
		end
	end

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			reload_high_reg <= `RESET_RELOAD;
		end else if (wr_reload_high) begin
			reload_high_reg <= SFR_WDATA;
		end
	end

	// Read mux; unmapped addresses read zero.
	always @* begin
		if (sel_control) begin
			SFR_RDATA = control_reg;
		end else if (sel_reload_low) begin
			SFR_RDATA = reload_low_reg;
		end else if (sel_reload_high) begin
			SFR_RDATA = reload_high_reg;
		end else begin
			SFR_RDATA = `RDATA_UNMAPPED;
		end
	end

	assign THIRD_TIMER_OVERFLOW = overflow;
	assign THIRD_TIMER_IRQ      = third_timer_overflow_flag;

	assign PORT0_BAUD_TICK = port0_baud_source_select ? overflow : FIRST_TIMER_OVERFLOW;

	assign PORT1_BAUD_DOUBLE = port1_baud_double && PORT1_MODE2;

	assign PORT1_MODE_BIT0_WE     = PORT1_CTL7_WRITE && !port1_error_access_select;
	assign PORT1_FRAMING_ERROR_WE = PORT1_CTL7_WRITE && port1_error_access_select;
	assign PORT1_CTL7_WDATA_OUT   = PORT1_CTL7_WDATA;
	assign PORT1_CTL7_READ        = port1_error_access_select ? PORT1_FRAMING_ERROR : PORT1_MODE_BIT0;

endmodule // timer3_control

// *** pkg/timer3_defs.vh ***
`ifndef TIMER3_DEFS_VH
`define TIMER3_DEFS_VH

// Register addresses.
`define ADDR_CONTROL        8'hc4
`define ADDR_RELOAD_LOW     8'hc5
`define ADDR_RELOAD_HIGH    8'hc6

// Control register fields.
`define CTL_BAUD_DOUBLE     7
`define CTL_ERR_SELECT      6
`define CTL_BAUD_SOURCE     5
`define CTL_OVF_FLAG        4
`define CTL_RUN             3
`define CTL_PS_HI           2
`define CTL_PS_LO           0

// Reset values.
`define RESET_CONTROL       8'h00
`define RESET_RELOAD        8'h00
`define RDATA_UNMAPPED      8'h00

// Timer geometry.
`define TIMER_WIDTH         16
`define PS_WIDTH            3
`define PS_COUNT_WIDTH      7
`define COUNT_MAX           16'hffff

`endif

// *** logic/prescale_divider.v ***
`timescale 1ns/100ps
`include "timer3_defs.vh"

module prescale_divider #(
	parameter SEL_WIDTH = `PS_WIDTH,
	parameter CNT_WIDTH = `PS_COUNT_WIDTH
) (
	// Clock and reset.
	input  wire                 clk,
	input  wire                 rst,
	// Control.
	input  wire                 enable,
	input  wire [SEL_WIDTH-1:0] select,
	// Tick out.
	output wire                 tick
);

	reg  [CNT_WIDTH-1:0] count_reg;
	wire [CNT_WIDTH-1:0] limit;

	// The limit is divisor minus one, so code zero ticks every cycle.
	assign limit = ({{(CNT_WIDTH-1){1'b0}}, 1'b1} << select) - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
	assign tick  = enable && (count_reg >= limit);

	// A halted timer restarts its prescale phase from zero.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= {CNT_WIDTH{1'b0}};
		end else if (!enable || tick) begin
			count_reg <= {CNT_WIDTH{1'b0}};
		end else begin
			count_reg <= count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule // prescale_divider

// *** dv/timer3_monitor.sv ***
`timescale 1ns/100ps
module timer3_monitor (
	input wire       CLOCK, RST, SFR_WE, INT_ACK, FIRST_TIMER_OVERFLOW, PORT0_BAUD_TICK, THIRD_TIMER_OVERFLOW,
	input wire       THIRD_TIMER_IRQ, PORT1_MODE2, PORT1_BAUD_DOUBLE, PORT1_CTL7_WRITE, PORT1_MODE_BIT0_WE,
	input wire       PORT1_MODE_BIT0, PORT1_FRAMING_ERROR, PORT1_CTL7_READ,
	input wire [7:0] SFR_ADDR, SFR_WDATA
);
	// Shadow of the control byte; only software changes the select bits.
	reg  [7:0] ctl_reg;
	wire       ctl_we = SFR_WE && SFR_ADDR == 8'hc4;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) ctl_reg <= 8'h00;
		else if (ctl_we) ctl_reg <= SFR_WDATA;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	a_halt_quiet: assert property (!ctl_reg[3] |-> !THIRD_TIMER_OVERFLOW)
		else $error("overflow while halted");
	a_ovf_sets_flag: assert property (THIRD_TIMER_OVERFLOW |=> THIRD_TIMER_IRQ)
		else $error("flag not set");
	a_ack_clears: assert property (INT_ACK && !THIRD_TIMER_OVERFLOW |=> !THIRD_TIMER_IRQ)
		else $error("flag not cleared");
	a_sw_flag: assert property (ctl_we && !INT_ACK && !THIRD_TIMER_OVERFLOW |=> THIRD_TIMER_IRQ == ctl_reg[4])
		else $error("flag write lost");
	a_baud_source: assert property (PORT0_BAUD_TICK == (ctl_reg[5] ? THIRD_TIMER_OVERFLOW : FIRST_TIMER_OVERFLOW))
		else $error("wrong baud source");
	a_baud_double: assert property (PORT1_BAUD_DOUBLE == (ctl_reg[7] && PORT1_MODE2))
		else $error("wrong baud double");
	a_err_strobe: assert property (PORT1_CTL7_WRITE |-> PORT1_MODE_BIT0_WE != ctl_reg[6])
		else $error("wrong strobe route");
	a_err_read: assert property (PORT1_CTL7_READ == (ctl_reg[6] ? PORT1_FRAMING_ERROR : PORT1_MODE_BIT0))
		else $error("wrong read route");
	cover property (THIRD_TIMER_OVERFLOW);
	cover property (INT_ACK && THIRD_TIMER_IRQ);
	cover property (PORT1_BAUD_DOUBLE);
endmodule // timer3_monitor
bind timer3_control timer3_monitor mon_u (.*);

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`include "timer3_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t bad value", $time); end end
module testbench;
	reg        CLOCK = 0, RST = 1, SFR_WE = 0, INT_ACK = 0, FIRST_TIMER_OVERFLOW = 0, PORT1_MODE2 = 0;
	reg        PORT1_CTL7_WRITE = 0, PORT1_CTL7_WDATA = 0, PORT1_MODE_BIT0 = 0, PORT1_FRAMING_ERROR = 0;
	reg  [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00;
	wire [7:0] SFR_RDATA;
	wire       PORT0_BAUD_TICK, THIRD_TIMER_OVERFLOW, THIRD_TIMER_IRQ, PORT1_BAUD_DOUBLE, PORT1_MODE_BIT0_WE;
	wire       PORT1_FRAMING_ERROR_WE, PORT1_CTL7_WDATA_OUT, PORT1_CTL7_READ;
	int        err_total = 0, num_checks = 0, n;
	timer3_control dut_u (.*);
	initial forever #20 CLOCK = ~CLOCK;
	task end_sim;
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(negedge CLOCK);
		{SFR_ADDR, SFR_WDATA, SFR_WE} = {a, d, 1'b1};
		@(negedge CLOCK);
		SFR_WE = 0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		SFR_ADDR = a;
		#1 `CHK(SFR_RDATA, e)
	endtask
	// Counts cycles to the next overflow pulse, giving up at the cap.
	task wait_ovf(input int cap);
		n = 0;
		do begin @(negedge CLOCK); n++; end while (!THIRD_TIMER_OVERFLOW && n < cap);
	endtask
	task t_regs;
		rd(`ADDR_RELOAD_HIGH, 8'h00);
		wr(`ADDR_RELOAD_LOW, 8'hff);
		wr(`ADDR_RELOAD_HIGH, 8'hff);
		rd(`ADDR_RELOAD_LOW, 8'hff);
		rd(`ADDR_RELOAD_HIGH, 8'hff);
		rd(8'hc7, 8'h00);
	endtask
	task t_flag;
		wr(`ADDR_CONTROL, 8'h10);
		`CHK(THIRD_TIMER_IRQ, 1'b1)
		INT_ACK = 1;
		@(negedge CLOCK) INT_ACK = 0;
		`CHK(THIRD_TIMER_IRQ, 1'b0)
		wr(`ADDR_CONTROL, 8'h10);
		wr(`ADDR_CONTROL, 8'h00);
		`CHK(THIRD_TIMER_IRQ, 1'b0)
	endtask
	task t_route;
		for (int i = 0; i < 2; i++) begin
			wr(`ADDR_CONTROL, {i[0], i[0], i[0], 5'h00});
			{FIRST_TIMER_OVERFLOW, PORT1_MODE2, PORT1_CTL7_WRITE, PORT1_FRAMING_ERROR, PORT1_CTL7_WDATA} = 5'h1f;
			#1 `CHK(PORT0_BAUD_TICK, !i[0])
			`CHK(PORT1_BAUD_DOUBLE, i[0])
			`CHK(PORT1_MODE_BIT0_WE, !i[0])
			`CHK(PORT1_FRAMING_ERROR_WE, i[0])
			`CHK(PORT1_CTL7_READ, i[0])
			`CHK(PORT1_CTL7_WDATA_OUT, 1'b1)
			{FIRST_TIMER_OVERFLOW, PORT1_MODE2, PORT1_CTL7_WRITE, PORT1_FRAMING_ERROR, PORT1_CTL7_WDATA} = 5'h00;
			#1 `CHK(PORT1_BAUD_DOUBLE, 1'b0)
		end
	endtask
	// Reload of all ones makes every prescaled tick overflow; only the first run waits a full wrap.
	task t_prescale;
		for (int p = 0; p < 8; p++) begin
			wr(`ADDR_CONTROL, {5'h01, p[2:0]});
			wait_ovf(70000);
			wait_ovf(200);
			`CHK(n, 1 << p)
			`CHK(THIRD_TIMER_IRQ, 1'b1)
			wr(`ADDR_CONTROL, 8'h00);
			wait_ovf(300);
			`CHK(n, 300)
		end
	endtask
	// Reload of fffe overflows every second tick; swapped bytes would take 257 ticks.
	task t_reload;
		wr(`ADDR_RELOAD_LOW, 8'hfe);
		wr(`ADDR_RELOAD_HIGH, 8'hff);
		wr(`ADDR_CONTROL, 8'h08);
		wait_ovf(70000);
		wait_ovf(300);
		`CHK(n, 2)
		wr(`ADDR_CONTROL, 8'h00);
	endtask
	initial begin
		repeat (16) @(negedge CLOCK);
		RST = 0;
		t_regs;
		t_flag;
		t_route;
		t_prescale;
		t_reload;
		end_sim;
	end
	initial begin
		repeat (90000) @(posedge CLOCK);
		err_total++;
		end_sim;
	end
endmodule // testbench
